// ===== hw/brps_debounce.sv
// synchronise and debounce one pin, emit a pulse on its press edge
`timescale 1ns/1ps
module brps_debounce #(
    parameter int unsigned STABLE_CYC = 2_000_000
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // pin in, clean level and press pulse out
    input  wire logic pin,
    output logic      level,
    output logic      press
);
    localparam int CW = $clog2(STABLE_CYC + 1);

    logic          meta_r;
    logic          sync_r;
    logic          level_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          flip;

    assign flip    = (sync_r != level_r) && (cnt_r == CW'(STABLE_CYC - 1));
    assign cnt_nxt = (sync_r == level_r) ? '0 :
                     flip ? '0 : cnt_r + CW'(1);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r  <= 1'b0;
            sync_r  <= 1'b0;
            level_r <= 1'b0;
            cnt_r   <= '0;
            press   <= 1'b0;
        end else begin
            meta_r  <= pin;
            sync_r  <= meta_r;
            cnt_r   <= cnt_nxt;
            level_r <= flip ? sync_r : level_r;
            press   <= flip & sync_r;
        end
    end

    assign level = level_r;
endmodule : brps_debounce

// ===== hw/brps_pkg.sv
// shared constants and carrier types for the board reset/power sequencer
package brps_pkg;

    localparam int unsigned CLK_HZ         = 200_000_000;
    localparam int unsigned SEQ_DELAY_MS   = 500;
    localparam int unsigned SEQ_DELAY_CYC  = CLK_HZ / 1000 * SEQ_DELAY_MS;
    localparam int unsigned WDT_DEFAULT_MS = 2000;
    localparam int unsigned WDT_DEFAULT_CYC = CLK_HZ / 1000 * WDT_DEFAULT_MS;
    localparam int unsigned DEBOUNCE_MS    = 10;
    localparam int unsigned DEBOUNCE_CYC   = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned MS_TICK_CYC    = CLK_HZ / 1000;
    localparam int unsigned TEMP_W         = 8;
    localparam int unsigned NUM_SMBUS      = 5;

    // restore-after-ac-loss policy codes
    typedef enum logic [1:0] {
        BRPS_AC_POWER_ON  = 2'h0,
        BRPS_AC_LAST      = 2'h1,
        BRPS_AC_STAY_OFF  = 2'h2
    } brps_ac_policy_t;

    localparam brps_ac_policy_t AC_POLICY_RESET = BRPS_AC_LAST;

    typedef struct packed {
        logic [TEMP_W-1:0] cpu0_temp;
        logic [TEMP_W-1:0] cpu1_temp;
    } brps_temp_t;

    typedef struct packed {
        logic boot_done;
        logic wdt_expired;
        logic boot_on_alt;
        logic frb3_hw;
    } brps_frb_status_t;

endpackage : brps_pkg

// ===== hw/brps_seq.sv
// board reset and power sequencer inside the management controller
`timescale 1ns/1ps
module brps_seq
    import brps_pkg::*;
#(
    parameter int unsigned DELAY_CYC = SEQ_DELAY_CYC,
    parameter int unsigned WDT_CYC   = WDT_DEFAULT_CYC,
    parameter int unsigned DEB_CYC   = DEBOUNCE_CYC
) (
    // clock and standby reset (the only reset of this block)
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    // supply, front panel and memory alert pins
    input  wire logic             supply_power_good,
    input  wire logic             reset_switch_n,
    input  wire logic             power_button_n,
    input  wire logic             id_button_n,
    input  wire logic             mem_ecc_alert_n,
    // firmware-side controls, same clock
    input  brps_pkg::brps_ac_policy_t ac_policy,
    input  wire logic             boot_done,
    input  wire logic             wdt_kick,
    input  wire logic             mem_event_ack,
    input  brps_pkg::brps_temp_t  temp_in,
    input  wire logic             temp_valid,
    // private management bus clock lines, open drain
    input  wire logic [NUM_SMBUS-1:0] smbus_scl_in,
    output logic [NUM_SMBUS-1:0]  smbus_scl_out,
    output logic [NUM_SMBUS-1:0]  smbus_scl_oe_n,
    // outputs to processors, south bridge, panel
    output logic                  cpu_power_stable,
    output logic                  supply_on_req,
    output logic                  id_led,
    output logic                  default_boot_processor,
    output logic                  mem_error_event,
    output brps_pkg::brps_temp_t  temp_out,
    output brps_pkg::brps_frb_status_t fault_resilient_boot
);
    localparam int DW = $clog2(DELAY_CYC + 1);
    localparam int WW = $clog2(WDT_CYC + 1);

    typedef enum logic [2:0] {
        BRPS_ST_OFF,
        BRPS_ST_WAIT_PG,
        BRPS_ST_DELAY,
        BRPS_ST_RUN,
        BRPS_ST_HARD_RST
    } brps_state_t;

    brps_state_t state_r;
    brps_state_t state_nxt;

    // pin synchronisers for pins without debounce
    logic pg_meta_r;
    logic pg_sync_r;
    logic ecc_meta_r;
    logic ecc_sync_r;

    logic rst_press;
    logic pwr_press;
    logic id_press;

    logic [DW-1:0] dly_r;
    logic [DW-1:0] dly_nxt;
    logic          dly_done;

    logic [WW-1:0] wdt_r;
    logic [WW-1:0] wdt_nxt;
    logic          wdt_fire;
    logic          wdt_run_r;

    logic          on_r;
    logic          last_on_r;
    logic          ac_init_r;
    logic          id_led_r;
    logic          alt_r;
    logic          expired_r;
    logic          ecc_evt_r;
    logic          stable_r;
    logic          boot_done_r;
    brps_temp_t    temp_r;

    brps_debounce #(.STABLE_CYC(DEB_CYC)) u_rst_sw (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .pin     (~reset_switch_n),
        .level   (),
        .press   (rst_press)
    );

    brps_debounce #(.STABLE_CYC(DEB_CYC)) u_pwr_btn (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .pin     (~power_button_n),
        .level   (),
        .press   (pwr_press)
    );

    brps_debounce #(.STABLE_CYC(DEB_CYC)) u_id_btn (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .pin     (~id_button_n),
        .level   (),
        .press   (id_press)
    );

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pg_meta_r  <= 1'b0;
            pg_sync_r  <= 1'b0;
            ecc_meta_r <= 1'b0;
            ecc_sync_r <= 1'b0;
        end else begin
            pg_meta_r  <= supply_power_good;
            pg_sync_r  <= pg_meta_r;
            ecc_meta_r <= ~mem_ecc_alert_n;
            ecc_sync_r <= ecc_meta_r;
        end
    end

    // sequence delay; restarts on every state change
    assign dly_done = (dly_r == DW'(DELAY_CYC - 1));
    assign dly_nxt  = (state_nxt != state_r) ? '0 :
                      dly_done ? dly_r : dly_r + DW'(1);

    // power-on request follows button and ac policy
    logic on_nxt;
    assign on_nxt = ac_init_r ? on_r ^ pwr_press :
                    (ac_policy == BRPS_AC_POWER_ON) ? 1'b1 :
                    (ac_policy == BRPS_AC_LAST) ? last_on_r : 1'b0;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BRPS_ST_OFF:      if (on_r) state_nxt = BRPS_ST_WAIT_PG;
            BRPS_ST_WAIT_PG:  if (!on_r) state_nxt = BRPS_ST_OFF;
                              else if (pg_sync_r) state_nxt = BRPS_ST_DELAY;
            BRPS_ST_DELAY: begin
                if (!on_r || !pg_sync_r) state_nxt = BRPS_ST_WAIT_PG;
                else if (dly_done) state_nxt = BRPS_ST_RUN;
            end
            BRPS_ST_RUN: begin
                if (!on_r || !pg_sync_r) state_nxt = BRPS_ST_WAIT_PG;
                else if (rst_press || wdt_fire) begin
                    state_nxt = BRPS_ST_HARD_RST;
                end
            end
            BRPS_ST_HARD_RST: begin
                if (!on_r || !pg_sync_r) state_nxt = BRPS_ST_WAIT_PG;
                else if (dly_done) state_nxt = BRPS_ST_DELAY;
            end
            default:          state_nxt = BRPS_ST_OFF;
        endcase
    end

    // boot watchdog: armed at each power-stable rise, stopped by boot_done
    assign wdt_fire = wdt_run_r && (wdt_r == WW'(WDT_CYC - 1));
    assign wdt_nxt  = (!stable_r || wdt_kick) ? '0 :
                      wdt_run_r ? wdt_r + WW'(1) : wdt_r;

    // only standby reset clears on_r and ac_init_r; hard reset leaves them alone
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r   <= BRPS_ST_OFF;
            dly_r     <= '0;
            on_r      <= 1'b0;
            ac_init_r <= 1'b0;
            stable_r  <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            dly_r     <= dly_nxt;
            on_r      <= on_nxt;
            ac_init_r <= 1'b1;
            stable_r  <= (state_nxt == BRPS_ST_RUN);
        end
    end

    // last state survives only while standby power is up; default off
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_on_r <= 1'b0;
        end else if (ac_init_r) begin
            last_on_r <= on_r;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_r       <= '0;
            wdt_run_r   <= 1'b0;
            boot_done_r <= 1'b0;
            expired_r   <= 1'b0;
            alt_r       <= 1'b0;
        end else begin
            wdt_r       <= wdt_nxt;
            wdt_run_r   <= stable_r & ~boot_done_r & ~wdt_fire;
            boot_done_r <= stable_r & (boot_done_r | boot_done);
            expired_r   <= expired_r | wdt_fire;
            if (wdt_fire) begin
                alt_r <= ~alt_r;
            end
        end
    end

    // set wins over firmware acknowledge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ecc_evt_r <= 1'b0;
            id_led_r  <= 1'b0;
            temp_r    <= '0;
        end else begin
            ecc_evt_r <= ecc_sync_r | (ecc_evt_r & ~mem_event_ack);
            id_led_r  <= id_led_r ^ id_press;
            if (temp_valid) begin
                temp_r <= temp_in;
            end
        end
    end

    // clock lines always released (oe_n high); no other master exists
    assign smbus_scl_out  = '0;
    assign smbus_scl_oe_n = '1;

    assign cpu_power_stable       = stable_r;
    assign supply_on_req          = on_r;
    assign id_led                 = id_led_r;
    assign default_boot_processor = alt_r;
    assign mem_error_event        = ecc_evt_r;
    assign temp_out               = temp_r;
    assign fault_resilient_boot   = '{boot_done:   boot_done_r,
                                      wdt_expired: expired_r,
                                      boot_on_alt: alt_r,
                                      frb3_hw:     1'b1};
endmodule : brps_seq

// ===== test/brps_psu_model.sv
// behavioural supply and south bridge beside the sequencer
`timescale 1ns/1ps
module brps_psu_model #(
    parameter int unsigned LAG = 8
) (
    // clock
    input  logic ref_clk,
    // supply request, forced brown-out, good level
    input  logic supply_on_req,
    input  logic fault,
    output logic supply_power_good,
    // south bridge side
    input  logic cpu_power_stable,
    output logic pci_rst
);
    int unsigned cnt = 0;
    logic        stable_q = 1'b0;
    always @(posedge ref_clk) begin
        if (!supply_on_req || fault)
            cnt <= 0;
        else if (cnt < LAG)
            cnt <= cnt + 1;
        stable_q <= cpu_power_stable;
    end
    // good only after the rails had LAG cycles to settle
    assign supply_power_good = (cnt == LAG);
    assign pci_rst = cpu_power_stable && !stable_q;
endmodule : brps_psu_model

// ===== test/brps_seq_asserts.sv
// port assertions for the board reset/power sequencer
`timescale 1ns/1ps
module brps_seq_asserts
    import brps_pkg::*;
#(
    parameter int unsigned DELAY_CYC = 20
) (
    // clock and standby reset
    input logic                       ref_clk,
    input logic                       rst_b,
    // watched inputs
    input logic                       supply_power_good,
    input logic                       id_button_n,
    input logic                       mem_ecc_alert_n,
    input logic                       mem_event_ack,
    input brps_pkg::brps_temp_t       temp_in,
    input logic                       temp_valid,
    // watched outputs
    input logic [NUM_SMBUS-1:0]       smbus_scl_out,
    input logic [NUM_SMBUS-1:0]       smbus_scl_oe_n,
    input logic                       cpu_power_stable,
    input logic                       id_led,
    input logic                       mem_error_event,
    input brps_pkg::brps_temp_t       temp_out,
    input brps_pkg::brps_frb_status_t fault_resilient_boot
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // low time of power-stable, sets the floor for each rise
    logic [31:0] low_cnt_r;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            low_cnt_r <= '0;
        else if (cpu_power_stable)
            low_cnt_r <= '0;
        else
            low_cnt_r <= low_cnt_r + 32'h0000_0001;
    end
    sequence pg_loss_s;
        $fell(supply_power_good);
    endsequence
    ctrl_reset_a: assert property (
        $rose(rst_b) |-> !cpu_power_stable && !mem_error_event)
        else $error("outputs active after standby reset");
    stable_rise_a: assert property (
        $rose(cpu_power_stable) |-> $past(supply_power_good, DELAY_CYC))
        else $error("power stable without settled supply");
    stable_gap_a: assert property (
        $rose(cpu_power_stable) |-> low_cnt_r >= DELAY_CYC)
        else $error("power stable low time too short");
    pg_loss_a: assert property (
        pg_loss_s |-> ##[1:4] !cpu_power_stable)
        else $error("power stable kept after supply loss");
    id_toggle_a: assert property (
        $changed(id_led) |-> $past(!id_button_n, 2))
        else $error("id led changed without a press");
    ecc_flag_a: assert property (
        $fell(mem_ecc_alert_n) |-> ##[1:4] mem_error_event)
        else $error("memory alert not flagged");
    ecc_hold_a: assert property (
        mem_error_event && !mem_event_ack |=> mem_error_event)
        else $error("memory event lost without ack");
    temp_load_a: assert property (
        temp_valid |=> temp_out == $past(temp_in))
        else $error("temperature not loaded");
    bus_release_a: assert property (
        smbus_scl_oe_n == '1 && smbus_scl_out == '0)
        else $error("private bus clock not idle");
    frb3_hw_a: assert property (
        fault_resilient_boot.frb3_hw)
        else $error("boot recovery support flag low");
endmodule : brps_seq_asserts

bind brps_seq brps_seq_asserts #(.DELAY_CYC(DELAY_CYC)) u_brps_seq_asserts (
    .ref_clk, .rst_b, .supply_power_good, .id_button_n, .mem_ecc_alert_n,
    .mem_event_ack, .temp_in, .temp_valid, .smbus_scl_out, .smbus_scl_oe_n,
    .cpu_power_stable, .id_led, .mem_error_event, .temp_out,
    .fault_resilient_boot);

// ===== test/brps_seq_tb_top.sv
// self-checking bench for the board reset/power sequencer
`timescale 1ns/1ps
module brps_seq_tb_top;
    import brps_pkg::*;
    localparam int unsigned D = 20;
    localparam int unsigned W = 100;
    logic ref_clk = 1'b0, rst_b = 1'b0, fault = 1'b0, led_exp = 1'b0;
    logic boot_done = 1'b1, wdt_kick = 1'b0, mem_event_ack = 1'b0;
    logic temp_valid = 1'b0, mem_ecc_alert_n = 1'b1;
    logic [2:0] btn_n = 3'h7;
    brps_ac_policy_t ac_policy = BRPS_AC_POWER_ON;
    brps_temp_t temp_in = '0, temp_out, exp_t;
    brps_frb_status_t fault_resilient_boot;
    logic supply_power_good, supply_on_req, cpu_power_stable, id_led;
    logic default_boot_processor, mem_error_event;
    logic [NUM_SMBUS-1:0] smbus_scl_in, smbus_scl_out, smbus_scl_oe_n;
    int seed = 32'hba44_5f15;
    int fails = 0, total_checks = 0, n = 0;
    always #2.5 ref_clk = ~ref_clk;
    // open-drain clock lines with pull-ups
    assign smbus_scl_in = smbus_scl_oe_n | smbus_scl_out;
    brps_seq #(.DELAY_CYC(D), .WDT_CYC(W), .DEB_CYC(4)) u_brps_seq (
        .ref_clk, .rst_b, .supply_power_good, .reset_switch_n(btn_n[0]),
        .power_button_n(btn_n[1]), .id_button_n(btn_n[2]),
        .mem_ecc_alert_n, .ac_policy, .boot_done, .wdt_kick, .mem_event_ack,
        .temp_in, .temp_valid, .smbus_scl_in, .smbus_scl_out, .smbus_scl_oe_n,
        .cpu_power_stable, .supply_on_req, .id_led, .default_boot_processor,
        .mem_error_event, .temp_out, .fault_resilient_boot);
    brps_psu_model u_brps_psu_model (.ref_clk, .supply_on_req, .fault,
        .supply_power_good, .cpu_power_stable, .pci_rst());
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test;
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic tk(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask : tk
    // wait for stable (or supply good) to reach v; n holds cycles spent
    task automatic wt(input logic v, input bit pg, input int lim);
        for (n = 0; (pg ? supply_power_good : cpu_power_stable) !== v; n++) begin
            if (n == lim) begin
                fails++;
                finish_test();
            end
            tk(1);
        end
    endtask : wt
    task automatic press(input int b);
        btn_n[b] = 1'b0;
        tk(12);
        btn_n[b] = 1'b1;
        tk(12);
    endtask : press
    task automatic do_reset(input brps_ac_policy_t p);
        rst_b = 1'b0;
        ac_policy = p;
        led_exp = 1'b0;
        tk(20);
        rst_b = 1'b1;
        tk(3);
        chk(supply_on_req, p == BRPS_AC_POWER_ON);
        chk(cpu_power_stable, 1'b0);
    endtask : do_reset
    initial begin
        for (int i = 2; i >= 0; i--)
            do_reset(brps_ac_policy_t'(i));
        wt(1, 1, 40);
        wt(1, 0, D + 10);
        chk(n >= D && n <= D + 6, 1'b1);
        press(2);
        led_exp = ~led_exp;
        chk(id_led, led_exp);
        // hard reset: press until stable drops, then time the gap
        btn_n[0] = 1'b0;
        wt(0, 0, 20);
        btn_n[0] = 1'b1;
        wt(1, 0, 3 * D);
        chk(n >= 2 * D - 2 && n <= 2 * D + 6, 1'b1);
        chk(id_led, led_exp);
        press(2);
        led_exp = ~led_exp;
        chk(id_led, led_exp);
        mem_ecc_alert_n = 1'b0;
        tk(3 + $unsigned($random(seed)) % 4);
        mem_ecc_alert_n = 1'b1;
        tk(5);
        chk(mem_error_event, 1'b1);
        mem_event_ack = 1'b1;
        tk(1);
        mem_event_ack = 1'b0;
        tk(2);
        chk(mem_error_event, 1'b0);
        for (int i = 0; i < 6; i++) begin
            temp_in = (i == 0) ? 16'hff00 : 16'($random(seed));
            wdt_kick = 1'($random(seed));
            temp_valid = 1'b1;
            exp_t = temp_in;
            tk(1);
            temp_valid = 1'b0;
            temp_in = ~temp_in;
            chk(temp_out, exp_t);
            tk(1);
            chk(temp_out, exp_t);
        end
        // hang in self test: no boot done, no kicks; a hard reset re-arms
        // the watchdog, since boot done is sticky while power is stable
        boot_done = 1'b0;
        wdt_kick = 1'b0;
        press(0);
        wt(1, 0, 3 * D);
        wt(0, 0, W + 20);
        chk(fault_resilient_boot, 4'h7);
        chk(default_boot_processor, 1'b1);
        boot_done = 1'b1;
        wt(1, 0, 3 * D + 20);
        fault = 1'b1;
        tk(6);
        chk(cpu_power_stable, 1'b0);
        fault = 1'b0;
        wt(1, 0, D + 30);
        do_reset(BRPS_AC_LAST);
        finish_test();
    end
endmodule : brps_seq_tb_top
